// >>> pdc_pkg.sv
// Constants and types shared by the device capability and control register bank.
package pdc_pkg;
  typedef logic [11:0] pdc_addr_t;
  typedef logic [2:0] pdc_mps_t;

  localparam pdc_addr_t DEV_CAP_OFS = 12'h0C4;
  localparam pdc_addr_t DEV_CTL_OFS = 12'h0C8;

  localparam int CAP_MPS_LSB = 0;
  localparam int CAP_PHANTOM_LSB = 3;
  localparam int CAP_EXT_TAG_BIT = 5;
  localparam int CAP_L0S_LSB = 6;
  localparam int CAP_L1_LSB = 9;
  localparam int CAP_RBER_BIT = 15;
  localparam int CAP_SPL_VAL_LSB = 18;
  localparam int CAP_SPL_SCL_LSB = 26;

  localparam int CTL_ERR_EN_LSB = 0;
  localparam int CTL_MPS_LSB = 5;
  localparam int CTL_AUX_PM_BIT = 10;
  localparam int STS_ERR_LSB = 16;
  localparam int STS_AUX_DET_BIT = 20;

  localparam pdc_mps_t MPS_SUP_SMALL = 3'h1;
  localparam pdc_mps_t MPS_SUP_LARGE = 3'h2;
  localparam pdc_mps_t CTL_MPS_RST = 3'h0;
  localparam logic RBER_RST = 1'b1;
  localparam logic [3:0] ERR_EN_RST = 4'h0;
  localparam logic [3:0] ERR_DET_RST = 4'h0;
  localparam logic [7:0] SPL_VAL_RST = 8'h00;
  localparam logic [1:0] SPL_SCL_RST = 2'h0;
  localparam logic AUX_PM_RST = 1'b0;

  // Edges after reset release before the synchronised strap is trusted.
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
endpackage : pdc_pkg

// >>> pdc_reg_if.sv
// Register access strobes passed from the APB front end to the register bank.
`timescale 1ns/1ps
interface pdc_reg_if;
  logic wr_stb;
  pdc_pkg::pdc_addr_t addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic hit;

  modport front (output wr_stb, output addr, output wdata, input rdata, input hit);
  modport bank (input wr_stb, input addr, input wdata, output rdata, output hit);
endinterface : pdc_reg_if

// >>> pdc_apb_slave.sv
// APB slave front end with one wait state and registered answers.
`timescale 1ns/1ps
module pdc_apb_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire pdc_pkg::pdc_addr_t paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pdc_reg_if.front bus
);
  import pdc_pkg::*;

  logic access;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  assign access = psel & penable;
  assign bus.addr = paddr;
  assign bus.wdata = pwdata;
  // Writes land only on the edge where the master samples pready high.
  assign bus.wr_stb = access & pready_reg & pwrite & bus.hit;

  always_comb begin
    pready_next = access & ~pready_reg;
    pslverr_next = access & ~pready_reg & ~bus.hit;
    prdata_next = (access & ~pready_reg & ~pwrite) ? bus.rdata : 32'h0000_0000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

  apb_one_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable ##1 psel && penable |-> !pready ##1 pready)
    else $error("APB answer did not come after exactly one wait cycle");
endmodule : pdc_apb_slave

// >>> pdc_regs.sv
// Device capability, control and status register bank of one switch port.
`timescale 1ns/1ps
module pdc_regs #(
  parameter bit IS_UPSTREAM = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic aux_rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire pdc_pkg::pdc_addr_t paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic large_payload_strap,
  input wire logic aux_power_present,
  input wire logic load_valid,
  input wire pdc_pkg::pdc_mps_t load_mps_sup,
  input wire logic load_rber,
  input wire logic spl_valid,
  input wire logic [7:0] spl_value,
  input wire logic [1:0] spl_scale,
  input wire logic [3:0] err_event,
  output logic [3:0] err_report_en,
  output pdc_pkg::pdc_mps_t max_payload,
  output logic aux_pm_en,
  output logic [7:0] slot_power_value,
  output logic [1:0] slot_power_scale,
  output logic [3:0] err_detected
);
  import pdc_pkg::*;

  pdc_reg_if bus ();

  pdc_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .bus(bus)
  );

  logic strap_meta_reg;
  logic strap_sync_reg;
  logic auxdet_meta_reg;
  logic auxdet_sync_reg;
  logic [1:0] settle_reg;
  logic [1:0] settle_next;
  logic settle_done;
  pdc_mps_t mps_sup_reg;
  pdc_mps_t mps_sup_next;
  logic rber_reg;
  logic rber_next;
  logic [7:0] spl_val_reg;
  logic [7:0] spl_val_next;
  logic [1:0] spl_scl_reg;
  logic [1:0] spl_scl_next;
  logic [3:0] err_en_reg;
  logic [3:0] err_en_next;
  pdc_mps_t ctl_mps_reg;
  pdc_mps_t ctl_mps_next;
  logic [3:0] err_det_reg;
  logic [3:0] err_det_next;
  logic aux_pm_reg;
  logic aux_pm_next;
  logic wr_ctl;
  pdc_mps_t wr_mps;
  logic [3:0] wr_err_en;
  logic [3:0] wr_err_clr;
  logic wr_aux_pm;
  logic [31:0] cap_word;
  logic [31:0] ctl_word;

  // Both pins come from outside the clock domain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
      auxdet_meta_reg <= 1'b0;
      auxdet_sync_reg <= 1'b0;
    end else begin
      strap_meta_reg <= large_payload_strap;
      strap_sync_reg <= strap_meta_reg;
      auxdet_meta_reg <= aux_power_present;
      auxdet_sync_reg <= auxdet_meta_reg;
    end
  end

  assign settle_done = (settle_reg == STRAP_SETTLE);
  assign wr_ctl = bus.wr_stb && (bus.addr == DEV_CTL_OFS);
  assign wr_mps = bus.wdata[CTL_MPS_LSB +: 3];
  assign wr_err_en = bus.wdata[CTL_ERR_EN_LSB +: 4];
  assign wr_err_clr = bus.wdata[STS_ERR_LSB +: 4];
  assign wr_aux_pm = bus.wdata[CTL_AUX_PM_BIT];

  // Capability defaults: the strap is followed until the settle count completes, and a load wins at any time, even while settling.
  always_comb begin
    settle_next = settle_done ? settle_reg : settle_reg + 2'h1;
    mps_sup_next = mps_sup_reg;
    rber_next = rber_reg;
    if (!settle_done) begin
      mps_sup_next = strap_sync_reg ? MPS_SUP_LARGE : MPS_SUP_SMALL;
    end
    if (load_valid) begin
      mps_sup_next = load_mps_sup;
      rber_next = load_rber;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_reg <= 2'h0;
      mps_sup_reg <= MPS_SUP_SMALL;
      rber_reg <= RBER_RST;
    end else begin
      settle_reg <= settle_next;
      mps_sup_reg <= mps_sup_next;
      rber_reg <= rber_next;
    end
  end

  // Slot power limit is captured only on the upstream port.
  always_comb begin
    spl_val_next = spl_val_reg;
    spl_scl_next = spl_scl_reg;
    if (IS_UPSTREAM && spl_valid) begin
      spl_val_next = spl_value;
      spl_scl_next = spl_scale;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spl_val_reg <= SPL_VAL_RST;
      spl_scl_reg <= SPL_SCL_RST;
    end else begin
      spl_val_reg <= spl_val_next;
      spl_scl_reg <= spl_scl_next;
    end
  end

  // Control writes and the detected-error flags; a new error beats a clear in the same cycle.
  always_comb begin
    err_en_next = err_en_reg;
    ctl_mps_next = ctl_mps_reg;
    err_det_next = err_det_reg;
    if (wr_ctl) begin
      err_en_next = wr_err_en;
      ctl_mps_next = (wr_mps > mps_sup_reg) ? mps_sup_reg : wr_mps;
      err_det_next = err_det_reg & ~wr_err_clr;
    end
    err_det_next = err_det_next | err_event;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_en_reg <= ERR_EN_RST;
      ctl_mps_reg <= CTL_MPS_RST;
      err_det_reg <= ERR_DET_RST;
    end else begin
      err_en_reg <= err_en_next;
      ctl_mps_reg <= ctl_mps_next;
      err_det_reg <= err_det_next;
    end
  end

  // The aux power enable survives a port reset and clears only on the aux reset.
  always_comb begin
    aux_pm_next = wr_ctl ? wr_aux_pm : aux_pm_reg;
  end

  always_ff @(posedge pclk or negedge aux_rstn) begin
    if (!aux_rstn) begin
      aux_pm_reg <= AUX_PM_RST;
    end else begin
      aux_pm_reg <= aux_pm_next;
    end
  end

  // Read views; every unlisted bit is constant zero and no write reaches it.
  always_comb begin
    cap_word = 32'h0000_0000;
    cap_word[CAP_MPS_LSB +: 3] = mps_sup_reg;
    cap_word[CAP_RBER_BIT] = rber_reg;
    cap_word[CAP_SPL_VAL_LSB +: 8] = spl_val_reg;
    cap_word[CAP_SPL_SCL_LSB +: 2] = spl_scl_reg;
    ctl_word = 32'h0000_0000;
    ctl_word[CTL_ERR_EN_LSB +: 4] = err_en_reg;
    ctl_word[CTL_MPS_LSB +: 3] = ctl_mps_reg;
    ctl_word[CTL_AUX_PM_BIT] = aux_pm_reg;
    ctl_word[STS_ERR_LSB +: 4] = err_det_reg;
    ctl_word[STS_AUX_DET_BIT] = auxdet_sync_reg;
  end

  assign bus.hit = (bus.addr == DEV_CAP_OFS) || (bus.addr == DEV_CTL_OFS);
  assign bus.rdata = (bus.addr == DEV_CAP_OFS) ? cap_word : ((bus.addr == DEV_CTL_OFS) ? ctl_word : 32'h0000_0000);

  assign err_report_en = err_en_reg;
  assign max_payload = ctl_mps_reg;
  assign aux_pm_en = aux_pm_reg;
  assign slot_power_value = spl_val_reg;
  assign slot_power_scale = spl_scl_reg;
  assign err_detected = err_det_reg;

  logic rd_cap_done;
  logic rd_ctl_done;
  assign rd_cap_done = psel && penable && pready && !pwrite && (paddr == DEV_CAP_OFS);
  assign rd_ctl_done = psel && penable && pready && !pwrite && (paddr == DEV_CTL_OFS);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  strap_default_a: assert property ($rose(settle_done) && !$past(load_valid) |->
    mps_sup_reg == ($past(strap_sync_reg) ? MPS_SUP_LARGE : MPS_SUP_SMALL))
    else $error("Supported payload size did not follow the strap");
  mps_sup_hold_a: assert property (settle_done && !load_valid |=> mps_sup_reg == $past(mps_sup_reg))
    else $error("Supported payload size changed without a load");
  phantom_zero_a: assert property (rd_cap_done |-> prdata[CAP_PHANTOM_LSB +: 2] == 2'h0)
    else $error("Phantom functions field read nonzero");
  ext_tag_zero_a: assert property (rd_cap_done |-> !prdata[CAP_EXT_TAG_BIT])
    else $error("Extended tag supported bit read nonzero");
  latency_zero_a: assert property (rd_cap_done |-> prdata[CAP_L1_LSB +: 3] == 3'h0 &&
    prdata[CAP_L0S_LSB +: 3] == 3'h0)
    else $error("Acceptable latency field read nonzero");
  rber_load_a: assert property (load_valid |=> rber_reg == $past(load_rber))
    else $error("Role-based error bit missed a load");
  spl_capture_a: assert property (spl_valid |=> spl_val_reg == (IS_UPSTREAM ? $past(spl_value) : 8'h00))
    else $error("Slot power value not captured correctly");
  err_en_write_a: assert property (wr_ctl |=> err_report_en == $past(wr_err_en))
    else $error("Error reporting enables did not take the write");
  ctl_ro_zero_a: assert property (rd_ctl_done |-> !prdata[4] && !prdata[11] && prdata[9:8] == 2'h0)
    else $error("Read-only control enable read nonzero");
  mps_clamp_a: assert property (wr_ctl |=> max_payload ==
    (($past(wr_mps) > $past(mps_sup_reg)) ? $past(mps_sup_reg) : $past(wr_mps)))
    else $error("Payload size setting not clamped to the supported size");
  aux_pm_write_a: assert property (wr_ctl && aux_rstn |=> aux_pm_en == $past(wr_aux_pm))
    else $error("Aux power enable did not take the write");
  mrrs_zero_a: assert property (rd_ctl_done |-> prdata[15:12] == 4'h0)
    else $error("Read request size or reserved bit read nonzero");
  err_record_a: assert property (|err_event |=> (err_detected & $past(err_event)) == $past(err_event))
    else $error("Detected error was not recorded");
  rsvd_zero_a: assert property (rd_cap_done |-> prdata[31:28] == 4'h0 && prdata[17:16] == 2'h0 &&
    prdata[14:12] == 3'h0)
    else $error("Reserved capability bits read nonzero");

  // The clear of a detected flag never wins over an error on the same edge.
  err_clear_a: assert property (wr_ctl |=> err_detected ==
    (($past(err_detected) & ~$past(wr_err_clr)) | $past(err_event)))
    else $error("Detected error flags did not follow the clear and the new errors");
  snoop_zero_a: assert property (rd_ctl_done |-> !prdata[11])
    else $error("No snoop enable read nonzero");
  tag_en_zero_a: assert property (rd_ctl_done |-> prdata[9:8] == 2'h0)
    else $error("Extended tag or phantom function enable read nonzero");
  sts_rsvd_a: assert property (rd_ctl_done |-> prdata[31:21] == 11'h000 && !prdata[15])
    else $error("Reserved control or status bits read nonzero");
  mps_load_a: assert property (load_valid |=> mps_sup_reg == $past(load_mps_sup))
    else $error("Supported payload size missed a load");
  mps_write_a: assert property (wr_ctl && wr_mps <= mps_sup_reg |=> max_payload == $past(wr_mps))
    else $error("Payload size setting did not take a legal write");
  spl_hold_a: assert property (!spl_valid |=> slot_power_value == $past(slot_power_value) &&
    slot_power_scale == $past(slot_power_scale))
    else $error("Slot power limit changed without a message");
  // Stickiness is watched under the aux reset alone, so it also holds while the port reset is low.
  aux_sticky_a: assert property (@(posedge pclk) disable iff (!aux_rstn)
    !wr_ctl |=> aux_pm_en == $past(aux_pm_en))
    else $error("Aux power enable changed without a write");

  clamp_seen_c: cover property (wr_ctl && wr_mps > mps_sup_reg);
  spl_seen_c: cover property (spl_valid ##[1:8] rd_cap_done);
  sticky_seen_c: cover property (@(posedge pclk) disable iff (!aux_rstn) !presetn && aux_pm_en);
  clr_race_c: cover property (wr_ctl && |(wr_err_clr & err_event));
  load_seen_c: cover property (settle_done && load_valid);
endmodule : pdc_regs

// >>> test_pcie_device_cap_ctrl_regs.sv
// Self-checking testbench for the device capability and control register bank.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); fails++; end end
module test_pcie_device_cap_ctrl_regs;
  import pdc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic aux_rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  pdc_addr_t paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic large_payload_strap = 1'b1;
  logic aux_power_present = 1'b1;
  logic load_valid = 1'b0, load_rber = 1'b0, spl_valid = 1'b0;
  pdc_mps_t load_mps_sup = 3'h0;
  logic [7:0] spl_value = 8'h00;
  logic [1:0] spl_scale = 2'h0;
  logic [3:0] err_event = 4'h0;
  logic [3:0] err_report_en, err_detected;
  pdc_mps_t max_payload, m;
  logic aux_pm_en;
  logic [7:0] slot_power_value;
  logic [1:0] slot_power_scale;
  logic [32:0] notes[$];
  logic [32:0] note;
  logic [31:0] w;
  int fails = 0;
  int n_compared = 0;
  integer seed;

  always #2 pclk = ~pclk;

  pdc_regs dut (.pclk(pclk), .presetn(presetn), .aux_rstn(aux_rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .large_payload_strap(large_payload_strap), .aux_power_present(aux_power_present),
    .load_valid(load_valid), .load_mps_sup(load_mps_sup), .load_rber(load_rber), .spl_valid(spl_valid),
    .spl_value(spl_value), .spl_scale(spl_scale), .err_event(err_event), .err_report_en(err_report_en),
    .max_payload(max_payload), .aux_pm_en(aux_pm_en), .slot_power_value(slot_power_value),
    .slot_power_scale(slot_power_scale), .err_detected(err_detected));

  // Every answer takes the oldest note; writes expect zero read data.
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (notes.size() == 0) begin
        $display("[FAIL] %s expected %h seen %h", "unrequested answer", 1'b0, pready);
        fails++;
      end else begin
        note = notes.pop_front();
        `CHK("prdata", note[31:0], prdata)
        `CHK("pslverr", note[32], pslverr)
      end
    end
  end

  task automatic apb(input logic wr, input pdc_addr_t a, input logic [31:0] d, input logic [31:0] exp,
      input logic err);
    int n;
    n = 0;
    notes.push_back({err, (wr | err) ? 32'h0000_0000 : exp});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      $display("[FAIL] %s expected %h seen %h", "pready", 1'b1, pready);
      fails++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (3000) @(posedge pclk);
    fails++;
    report_and_stop();
  end

  initial begin
    seed = 77976;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    aux_rstn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, DEV_CAP_OFS, 32'h0, 32'h0000_8002, 1'b0);
    apb(1'b0, DEV_CTL_OFS, 32'h0, 32'h0010_0000, 1'b0);
    apb(1'b1, DEV_CAP_OFS, 32'hFFFF_FFFF, 32'h0, 1'b0);
    apb(1'b0, DEV_CAP_OFS, 32'h0, 32'h0000_8002, 1'b0);
    apb(1'b1, 12'h0C0, 32'hFFFF_FFFF, 32'h0, 1'b1);
    apb(1'b0, 12'h0CC, 32'h0, 32'h0, 1'b1);
    for (int i = 0; i < 12; i++) begin
      w = $random(seed);
      if (i == 0) begin
        w = 32'hFFF0_FFFF;
      end
      m = (w[7:5] > MPS_SUP_LARGE) ? MPS_SUP_LARGE : w[7:5];
      apb(1'b1, DEV_CTL_OFS, w, 32'h0, 1'b0);
      apb(1'b0, DEV_CTL_OFS, 32'h0, {11'h0, 1'b1, 4'h0, 5'h0, w[10], 2'h0, m, 1'b0, w[3:0]}, 1'b0);
      `CHK("err_report_en", w[3:0], err_report_en)
      `CHK("max_payload", m, max_payload)
      `CHK("aux_pm_en", w[10], aux_pm_en)
    end
    load_mps_sup <= MPS_SUP_SMALL;
    load_rber <= 1'b0;
    load_valid <= 1'b1;
    @(posedge pclk);
    load_valid <= 1'b0;
    spl_value <= 8'hA5;
    spl_scale <= 2'h3;
    spl_valid <= 1'b1;
    @(posedge pclk);
    spl_valid <= 1'b0;
    @(posedge pclk);
    apb(1'b0, DEV_CAP_OFS, 32'h0, 32'h0E94_0001, 1'b0);
    `CHK("slot_power_value", 8'hA5, slot_power_value)
    `CHK("slot_power_scale", 2'h3, slot_power_scale)
    apb(1'b1, DEV_CTL_OFS, 32'h0000_00E0, 32'h0, 1'b0);
    apb(1'b0, DEV_CTL_OFS, 32'h0, 32'h0010_0020, 1'b0);
    apb(1'b1, DEV_CTL_OFS, 32'h0000_0000, 32'h0, 1'b0);
    err_event <= 4'h5;
    @(posedge pclk);
    err_event <= 4'h0;
    @(posedge pclk);
    apb(1'b0, DEV_CTL_OFS, 32'h0, 32'h0015_0000, 1'b0);
    `CHK("err_detected", 4'h5, err_detected)
    apb(1'b1, DEV_CTL_OFS, 32'h0001_0400, 32'h0, 1'b0);
    apb(1'b0, DEV_CTL_OFS, 32'h0, 32'h0014_0400, 1'b0);
    `CHK("err_detected", 4'h4, err_detected)
    // An error and its clear landing on the same edge must leave the flag set.
    fork
      apb(1'b1, DEV_CTL_OFS, 32'h0004_0400, 32'h0, 1'b0);
      begin
        repeat (2) @(posedge pclk);
        err_event <= 4'h4;
        @(posedge pclk);
        err_event <= 4'h0;
      end
    join
    apb(1'b0, DEV_CTL_OFS, 32'h0, 32'h0014_0400, 1'b0);
    `CHK("err_detected after race", 4'h4, err_detected)
    // Strap changes only while reset is held, as the strap must be stable across release.
    presetn <= 1'b0;
    large_payload_strap <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("aux_pm_en", 1'b1, aux_pm_en)
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, DEV_CTL_OFS, 32'h0, 32'h0010_0400, 1'b0);
    apb(1'b0, DEV_CAP_OFS, 32'h0, 32'h0000_8001, 1'b0);
    repeat (3) @(posedge pclk);
    `CHK("pending notes", 0, notes.size())
    report_and_stop();
  end
endmodule : test_pcie_device_cap_ctrl_regs
